// >>> core/tcmc_channel.sv
`default_nettype none

module tcmc_channel (
  input wire logic clock,
  input wire logic rst,
  input wire tcmc_pkg::tcmc_bus_req_type bus,
  output logic [7:0] rdata,
  input wire logic prescaled_clock_a,
  input wire logic prescaled_clock_b,
  input wire logic master_interrupt,
  input wire logic channel3_input_pin,
  output logic channel3_interrupt,
  output logic timer_out,
  output logic counting
);
  import tcmc_pkg::*;

  tcmc_state_type s;
  tcmc_state_type n;
  logic rise;
  logic fall;
  logic valid_edge;
  logic start_edge;
  logic capt_edge;
  logic op_tick;
  logic cnt_tick;
  logic hw_start;
  logic hw_capt;
  logic end_trig;
  logic sw_start;
  logic sw_stop;
  logic begin_cnt;
  logic count_up;
  logic at_zero;
  logic [15:0] load;
  logic [15:0] cnt_inc;
  logic [15:0] cnt_dec;

  // ****************************************************************
  // trigger and clock decode
  // ****************************************************************

  // edges seen on the synchronised pin
  assign rise = s.sync2 & ~s.prev;
  assign fall = ~s.sync2 & s.prev;

  // valid, start and capture edges per edge code
  always_comb begin
    valid_edge = 1'b0;
    start_edge = 1'b0;
    capt_edge = 1'b0;
    case (s.ml.input_edge_select)
      EDGE_FALL: begin
        valid_edge = fall;
        start_edge = fall;
        capt_edge = fall;
      end
      EDGE_RISE: begin
        valid_edge = rise;
        start_edge = rise;
        capt_edge = rise;
      end
      EDGE_LOW_W: begin
        valid_edge = rise | fall;
        start_edge = fall;
        capt_edge = rise;
      end
      default: begin
        valid_edge = rise | fall;
        start_edge = rise;
        capt_edge = fall;
      end
    endcase
  end

  // count clock selection
  assign op_tick = s.mh.operation_clock_select ? prescaled_clock_b
                                               : prescaled_clock_a;
  assign cnt_tick = s.mh.count_clock_source ? valid_edge : op_tick;

  // hardware start, capture and end triggers per trigger code
  always_comb begin
    hw_start = 1'b0;
    hw_capt = 1'b0;
    end_trig = 1'b0;
    case (s.mh.trigger_source)
      TRIG_SOFT: begin
        hw_start = 1'b0;
      end
      TRIG_EDGE: begin
        hw_start = start_edge;
        hw_capt = capt_edge;
      end
      TRIG_BOTH: begin
        hw_start = rise | fall;
        hw_capt = rise | fall;
      end
      TRIG_MASTER: begin
        hw_start = master_interrupt;
      end
      TRIG_MASTER_END: begin
        hw_start = master_interrupt;
        end_trig = valid_edge;
      end
      default: begin
        hw_start = 1'b0;
      end
    endcase
  end

  // software control strobes
  assign sw_start = bus.wr && (bus.addr == OFF_CONTROL) &&
                    bus.wdata[CTRL_START_BIT];
  assign sw_stop = bus.wr && (bus.addr == OFF_CONTROL) &&
                   bus.wdata[CTRL_STOP_BIT];

  // counting begins from stop or wait
  assign begin_cnt = !sw_stop && (s.phase != PH_COUNT) &&
                     ((sw_start && s.mh.trigger_source == TRIG_SOFT) ||
                      (s.phase == PH_WAIT && hw_start));

  // direction and arithmetic at the active width
  assign count_up = (s.ml.op_mode == MODE_CAPTURE) ||
                    (s.ml.op_mode == MODE_CAPT_ONE);
  assign load = tcmc_mask(s.data, s.mh.width_split);
  assign cnt_inc = tcmc_mask(s.cnt + 16'h0001, s.mh.width_split);
  assign cnt_dec = tcmc_mask(s.cnt - 16'h0001, s.mh.width_split);
  assign at_zero = (tcmc_mask(s.cnt, s.mh.width_split) == RST_WORD);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = s;
    n.irq = 1'b0;
    n.rdata = RST_BYTE;
    n.sync1 = channel3_input_pin;
    n.sync2 = s.sync1;
    n.prev = s.sync2;

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        OFF_MODE_HIGH: n.mh = bus.wdata & MASK_MODE_HIGH;
        OFF_MODE_LOW: n.ml = bus.wdata & MASK_MODE_LOW;
        OFF_OUT_MODE: n.tom = bus.wdata & MASK_OUT_MODE;
        OFF_DATA_LOW: n.data[7:0] = bus.wdata;
        OFF_DATA_HIGH: n.data[15:8] = bus.wdata;
        default: n.tom = n.tom;
      endcase
    end

    // counting sequence
    if (sw_stop) begin
      n.phase = PH_STOP;
    end else if (begin_cnt) begin
      n.phase = PH_COUNT;
      n.cnt = count_up ? RST_WORD : load;
      if (s.ml.start_option_bit &&
          (s.ml.op_mode == MODE_INTERVAL ||
           s.ml.op_mode == MODE_CAPTURE)) begin
        n.irq = 1'b1;
      end
    end else if (sw_start && s.phase != PH_COUNT) begin
      n.phase = PH_WAIT;
    end else if (s.phase == PH_COUNT) begin
      case (s.ml.op_mode)
        MODE_INTERVAL, MODE_EVENT: begin
          // down counter with reload, no start interrupt in event mode
          if (cnt_tick) begin
            if (at_zero) begin
              n.cnt = load;
              n.irq = 1'b1;
            end else begin
              n.cnt = cnt_dec;
            end
          end
        end
        MODE_CAPTURE: begin
          // capture and restart from zero on each capture trigger
          if (hw_capt) begin
            n.cap = s.cnt;
            n.cnt = RST_WORD;
            n.irq = 1'b1;
          end else if (cnt_tick) begin
            n.cnt = cnt_inc;
          end
        end
        MODE_ONE_COUNT: begin
          // single pass down, optional retrigger
          if (end_trig) begin
            n.phase = PH_WAIT;
            n.irq = 1'b1;
          end else if (hw_start && s.ml.start_option_bit) begin
            n.cnt = load;
            n.irq = 1'b1;
          end else if (cnt_tick) begin
            if (at_zero) begin
              n.phase = PH_WAIT;
              n.irq = 1'b1;
            end else begin
              n.cnt = cnt_dec;
            end
          end
        end
        MODE_CAPT_ONE: begin
          // width measurement, start triggers ignored while counting
          if (hw_capt) begin
            n.cap = s.cnt;
            n.phase = PH_WAIT;
            n.irq = 1'b1;
          end else if (cnt_tick) begin
            n.cnt = cnt_inc;
          end
        end
        default: begin
          n.cnt = s.cnt;
        end
      endcase
    end

    // timer output
    if (s.tom[TOM_CH3_BIT]) begin
      if (n.irq) begin
        n.tout = 1'b0;
      end else if (master_interrupt) begin
        n.tout = 1'b1;
      end
    end else if (n.irq) begin
      n.tout = ~s.tout;
    end

    // register reads, data valid in the next cycle only
    if (bus.rd) begin
      case (bus.addr)
        OFF_MODE_HIGH: n.rdata = s.mh;
        OFF_MODE_LOW: n.rdata = s.ml;
        OFF_OUT_MODE: n.rdata = s.tom;
        OFF_DATA_LOW: n.rdata = s.data[7:0];
        OFF_DATA_HIGH: n.rdata = s.data[15:8];
        OFF_STATUS: begin
          n.rdata[STAT_RUN_BIT] = (s.phase == PH_COUNT);
          n.rdata[STAT_WAIT_BIT] = (s.phase == PH_WAIT);
          n.rdata[STAT_OUT_BIT] = s.tout;
        end
        OFF_COUNT_LOW: n.rdata = s.cnt[7:0];
        OFF_COUNT_HIGH: n.rdata = s.cnt[15:8];
        OFF_CAPT_LOW: n.rdata = s.cap[7:0];
        OFF_CAPT_HIGH: n.rdata = s.cap[15:8];
        default: n.rdata = RST_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // outputs
  assign rdata = s.rdata;
  assign channel3_interrupt = s.irq;
  assign timer_out = s.tout;
  assign counting = (s.phase == PH_COUNT);

  // ****************************************************************
  // checks
  // ****************************************************************

  soft_only_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase != PH_COUNT && s.mh.trigger_source == TRIG_SOFT &&
     !bus.wr) |=> (s.phase != PH_COUNT))
    else $error("channel started without software trigger");

  master_start_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_WAIT && s.mh.trigger_source == TRIG_MASTER &&
     master_interrupt && !bus.wr) |=> (s.phase == PH_COUNT))
    else $error("master interrupt did not start slave");

  edge_start_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_WAIT && s.mh.trigger_source == TRIG_EDGE &&
     s.ml.input_edge_select == EDGE_RISE && !bus.wr && $rose(s.sync2))
    |=> (s.phase == PH_COUNT))
    else $error("rising pin edge did not start channel");

  interval_reload_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_INTERVAL &&
     cnt_tick && at_zero && !bus.wr)
    |=> (s.irq && s.cnt == $past(load)))
    else $error("interval timer missed reload or interrupt");

  capture_up_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_CAPTURE &&
     cnt_tick && !hw_capt && !bus.wr)
    |=> (s.cnt == $past(cnt_inc) && !s.irq))
    else $error("capture mode did not count up");

  start_irq_a: assert property (
    @(posedge clock) disable iff (rst)
    (begin_cnt && s.ml.op_mode == MODE_INTERVAL)
    |=> (s.irq == $past(s.ml.start_option_bit)))
    else $error("start interrupt does not follow option bit");

  retrig_ignore_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_ONE_COUNT &&
     !s.ml.start_option_bit && hw_start && !cnt_tick && !end_trig &&
     !bus.wr) |=> (!s.irq && $stable(s.cnt)))
    else $error("one-count retriggered with option clear");

  width_ignore_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_CAPT_ONE &&
     hw_start && !hw_capt && !cnt_tick && !bus.wr)
    |=> (!s.irq && $stable(s.cnt) && s.phase == PH_COUNT))
    else $error("width measurement reacted to start trigger");

  toggle_out_a: assert property (
    @(posedge clock) disable iff (rst)
    (!s.tom[TOM_CH3_BIT] && n.irq) |=> (s.tout != $past(s.tout)))
    else $error("output did not toggle on interrupt");

  slave_set_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.tom[TOM_CH3_BIT] && master_interrupt && !n.irq) ##1 !s.irq
    |-> s.tout)
    else $error("slave output not set by master");

  split_width_a: assert property (
    @(posedge clock) disable iff (rst)
    (begin_cnt && s.mh.width_split) |=> (s.cnt[15:8] == 8'h00))
    else $error("split counter used upper byte");

  event_no_start_a: assert property (
    @(posedge clock) disable iff (rst)
    (begin_cnt && s.ml.op_mode == MODE_EVENT) |=> !s.irq)
    else $error("event counter raised a start interrupt");

  interval_down_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_INTERVAL &&
     cnt_tick && !at_zero && !bus.wr)
    |=> (s.cnt == $past(cnt_dec) && !s.irq))
    else $error("interval timer did not count down");

  pin_count_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_EVENT &&
     s.mh.count_clock_source && !valid_edge && !bus.wr)
    |=> ($stable(s.cnt) && !s.irq))
    else $error("event counter moved without a pin edge");

  one_count_end_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_ONE_COUNT &&
     cnt_tick && at_zero && !hw_start && !end_trig && !bus.wr)
    |=> (s.irq && s.phase == PH_WAIT))
    else $error("one-count did not end at zero");

  width_capture_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_CAPT_ONE &&
     hw_capt && !bus.wr)
    |=> (s.irq && s.phase == PH_WAIT && s.cap == $past(s.cnt)))
    else $error("width measurement did not capture and stop");

  low_width_start_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_WAIT && s.mh.trigger_source == TRIG_EDGE &&
     s.ml.input_edge_select == EDGE_LOW_W && fall && !bus.wr)
    |=> (s.phase == PH_COUNT))
    else $error("falling edge did not start low width count");

  end_trigger_a: assert property (
    @(posedge clock) disable iff (rst)
    (s.phase == PH_COUNT && s.ml.op_mode == MODE_ONE_COUNT &&
     s.mh.trigger_source == TRIG_MASTER_END && valid_edge &&
     !bus.wr) |=> (s.phase == PH_WAIT && s.irq))
    else $error("pin edge did not end one-shot slave");

endmodule

`default_nettype wire

// >>> core/tcmc_dummy_never.sv
`default_nettype none
`default_nettype wire

// >>> core/tcmc_pkg.sv
`default_nettype none

package tcmc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] OFF_MODE_HIGH = 4'h0;
  localparam logic [3:0] OFF_MODE_LOW = 4'h1;
  localparam logic [3:0] OFF_OUT_MODE = 4'h2;
  localparam logic [3:0] OFF_DATA_LOW = 4'h3;
  localparam logic [3:0] OFF_DATA_HIGH = 4'h4;
  localparam logic [3:0] OFF_CONTROL = 4'h5;
  localparam logic [3:0] OFF_STATUS = 4'h6;
  localparam logic [3:0] OFF_COUNT_LOW = 4'h7;
  localparam logic [3:0] OFF_COUNT_HIGH = 4'h8;
  localparam logic [3:0] OFF_CAPT_LOW = 4'h9;
  localparam logic [3:0] OFF_CAPT_HIGH = 4'ha;

  // writable bits and reset values
  localparam logic [7:0] MASK_MODE_HIGH = 8'h9f;
  localparam logic [7:0] MASK_MODE_LOW = 8'hcf;
  localparam logic [7:0] MASK_OUT_MODE = 8'h0a;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // field positions of own registers
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned STAT_RUN_BIT = 0;
  localparam int unsigned STAT_WAIT_BIT = 1;
  localparam int unsigned STAT_OUT_BIT = 2;
  localparam int unsigned TOM_CH1_BIT = 1;
  localparam int unsigned TOM_CH3_BIT = 3;

  // ****************************************************************
  // codes
  // ****************************************************************
  localparam logic [2:0] TRIG_SOFT = 3'h0;
  localparam logic [2:0] TRIG_EDGE = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_MASTER = 3'h4;
  localparam logic [2:0] TRIG_MASTER_END = 3'h6;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_LOW_W = 2'h2;
  localparam logic [1:0] EDGE_HIGH_W = 2'h3;
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_EVENT = 3'h3;
  localparam logic [2:0] MODE_ONE_COUNT = 3'h4;
  localparam logic [2:0] MODE_CAPT_ONE = 3'h6;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic operation_clock_select;
    logic [1:0] reserved;
    logic count_clock_source;
    logic width_split;
    logic [2:0] trigger_source;
  } tcmc_mode_high_type;

  typedef struct packed {
    logic [1:0] input_edge_select;
    logic [1:0] reserved;
    logic [2:0] op_mode;
    logic start_option_bit;
  } tcmc_mode_low_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcmc_bus_req_type;

  typedef enum logic [1:0] {PH_STOP, PH_WAIT, PH_COUNT} tcmc_phase_type;

  typedef struct packed {
    tcmc_mode_high_type mh;
    tcmc_mode_low_type ml;
    logic [7:0] tom;
    logic [15:0] data;
    logic [15:0] cnt;
    logic [15:0] cap;
    tcmc_phase_type phase;
    logic irq;
    logic tout;
    logic [7:0] rdata;
    logic sync1;
    logic sync2;
    logic prev;
  } tcmc_state_type;

  // limit a count to the active width
  function automatic logic [15:0] tcmc_mask(input logic [15:0] v,
                                            input logic split);
    tcmc_mask = split ? {8'h00, v[7:0]} : v;
  endfunction

endpackage

`default_nettype wire

// >>> verification/tcmc_channel_test.sv
`default_nettype none

`define CHK(a, b) begin \
  n_checks++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); \
  end \
end

module tcmc_channel_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tcmc_pkg::*;

  // ********
  // stimulus and design
  // ********
  logic clock, rst, tick_a, tick_b, master, pin, irq, tout, cnt_on;
  tcmc_bus_req_type bus;
  logic [7:0] rdata;
  int failures = 0, n_checks = 0, n_irq = 0, cycles = 0;
  logic [7:0] cmh [4] = '{8'h01, 8'h02, 8'h01, 8'h01};
  logic [7:0] cml [4] = '{8'h44, 8'h44, 8'hcc, 8'h8c};
  logic [7:0] cap_exp [4] = '{8'h09, 8'h03, 8'h03, 8'h05};
  int irq_exp [4] = '{1, 3, 2, 1};
  logic [7:0] wmh [3] = '{8'hfe, 8'hf9, 8'h80};
  logic [7:0] wml [3] = '{8'hfc, 8'hf6, 8'hf1};
  logic [7:0] rt_ml [3] = '{8'h08, 8'h09, 8'h0c};
  logic [7:0] rt_cnt [3] = '{8'h03, 8'h03, 8'h00};

  tcmc_channel i_dut (
    .clock(clock),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .prescaled_clock_a(tick_a),
    .prescaled_clock_b(tick_b),
    .master_interrupt(master),
    .channel3_input_pin(pin),
    .channel3_interrupt(irq),
    .timer_out(tout),
    .counting(cnt_on)
  );

  tcmc_pin_model i_pin (
    .clock(clock),
    .pin(pin)
  );

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // interrupt pulse count and hang guard
  always @(posedge clock) begin
    cycles++;
    if (irq === 1'b1) n_irq++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // ********
  // bus tasks
  // ********
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one-cycle write strobe, then one idle edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    @(posedge clock);
  endtask

  // one-cycle read strobe, data looked at in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
    @(posedge clock);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ********
  // test sequence
  // ********
  initial begin
    rst = 1'b1;
    tick_a = 1'b0;
    tick_b = 1'b0;
    master = 1'b0;
    bus = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // reset values, writable bits and an unmapped place
    for (int a = 0; a < 11; a++) begin
      rd(4'(a), RST_BYTE);
    end
    // writable bits, every written value a permitted setting
    foreach (wmh[i]) begin
      wr(OFF_MODE_HIGH, wmh[i]);
      wr(OFF_MODE_LOW, wml[i]);
      rd(OFF_MODE_HIGH, wmh[i] & MASK_MODE_HIGH);
      rd(OFF_MODE_LOW, wml[i] & MASK_MODE_LOW);
    end
    wr(OFF_OUT_MODE, 8'hff);
    rd(OFF_OUT_MODE, MASK_OUT_MODE);
    rd(4'hf, RST_BYTE);
    wr(OFF_OUT_MODE, 8'h00);
    // full or split width decides the loaded high byte
    wr(OFF_DATA_LOW, 8'h02);
    wr(OFF_DATA_HIGH, 8'h01);
    wr(OFF_MODE_LOW, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(OFF_MODE_HIGH, s ? 8'h08 : 8'h00);
      wr(OFF_CONTROL, 8'h01);
      rd(OFF_COUNT_HIGH, s ? 8'h00 : 8'h01);
      rd(OFF_COUNT_LOW, 8'h02);
      wr(OFF_CONTROL, 8'h02);
    end
    // interval mode: start interrupt, then one every three ticks
    tick_a <= 1'b1;
    wr(OFF_DATA_HIGH, 8'h00);
    wr(OFF_MODE_HIGH, 8'h00);
    wr(OFF_MODE_LOW, 8'h01);
    n_irq = 0;
    wr(OFF_CONTROL, 8'h01);
    cyc(6);
    wr(OFF_CONTROL, 8'h02);
    `CHK(n_irq, 3)
    `CHK(tout, 1'b1)
    // second prescaled clock stands still: start interrupt only
    wr(OFF_MODE_HIGH, 8'h80);
    n_irq = 0;
    wr(OFF_CONTROL, 8'h01);
    cyc(6);
    wr(OFF_CONTROL, 8'h02);
    `CHK(n_irq, 1)
    `CHK(tout, 1'b0)
    // software-only trigger: pin edges neither capture nor restart
    wr(OFF_MODE_HIGH, 8'h00);
    wr(OFF_MODE_LOW, 8'h44);
    n_irq = 0;
    wr(OFF_CONTROL, 8'h01);
    i_pin.pulse(4, 6);
    i_pin.pulse(4, 6);
    `CHK(n_irq, 0)
    `CHK(cnt_on, 1'b1)
    wr(OFF_CONTROL, 8'h02);
    // event counter on pin edges: three rising, two falling
    wr(OFF_DATA_LOW, 8'h00);
    wr(OFF_MODE_HIGH, 8'h10);
    for (int e = 0; e < 2; e++) begin
      wr(OFF_MODE_LOW, e ? 8'h46 : 8'h06);
      n_irq = 0;
      wr(OFF_CONTROL, 8'h01);
      i_pin.pulse(4, 4);
      i_pin.pulse(4, 4);
      i_pin.level(1'b1, 6);
      wr(OFF_CONTROL, 8'h02);
      i_pin.level(1'b0, 6);
      `CHK(n_irq, e ? 3 : 2)
    end
    // capture and width measurement, a tick every clock
    for (int k = 0; k < 4; k++) begin
      wr(OFF_MODE_HIGH, cmh[k]);
      wr(OFF_MODE_LOW, cml[k]);
      n_irq = 0;
      wr(OFF_CONTROL, 8'h01);
      i_pin.pulse(4, 6);
      i_pin.pulse(4, 6);
      wr(OFF_CONTROL, 8'h02);
      rd(OFF_CAPT_LOW, cap_exp[k]);
      `CHK(n_irq, irq_exp[k])
    end
    // master interrupt starts a one-count slave and sets its output
    wr(OFF_DATA_LOW, 8'h03);
    wr(OFF_MODE_HIGH, 8'h04);
    wr(OFF_MODE_LOW, 8'h09);
    wr(OFF_OUT_MODE, 8'h08);
    n_irq = 0;
    wr(OFF_CONTROL, 8'h01);
    `CHK(cnt_on, 1'b0)
    master <= 1'b1;
    @(posedge clock);
    master <= 1'b0;
    @(posedge clock);
    #1;
    `CHK(cnt_on, 1'b1)
    `CHK(tout, 1'b1)
    cyc(8);
    `CHK(tout, 1'b0)
    `CHK(cnt_on, 1'b0)
    `CHK(n_irq, 1)
    // start trigger while counting, count clock held still
    tick_a <= 1'b0;
    for (int o = 0; o < 3; o++) begin
      wr(OFF_MODE_LOW, rt_ml[o]);
      wr(OFF_CONTROL, 8'h01);
      n_irq = 0;
      master <= 1'b1;
      cyc(2);
      master <= 1'b0;
      cyc(2);
      `CHK(n_irq, (o == 1) ? 1 : 0)
      `CHK(tout, (o == 1) ? 1'b0 : 1'b1)
      rd(OFF_COUNT_LOW, rt_cnt[o]);
      wr(OFF_CONTROL, 8'h02);
    end
    // two-input one-shot slave: master starts, falling pin edge ends
    wr(OFF_MODE_HIGH, 8'h06);
    wr(OFF_MODE_LOW, 8'h08);
    wr(OFF_CONTROL, 8'h01);
    n_irq = 0;
    master <= 1'b1;
    @(posedge clock);
    master <= 1'b0;
    i_pin.pulse(4, 6);
    `CHK(n_irq, 1)
    `CHK(cnt_on, 1'b0)
    rd(OFF_STATUS, 8'h02);
    complete_run();
  end
endmodule

`default_nettype wire

// >>> verification/tcmc_pin_model.sv
`default_nettype none

module tcmc_pin_model (
  input wire logic clock,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // timer input pin source
  // ********

  // pin idles low, as behind a pull-down
  initial begin
    pin = 1'b0;
  end

  // one high pulse, then a low gap, both in clock cycles
  task automatic pulse(input int hi, input int lo);
    pin <= 1'b1;
    repeat (hi) @(posedge clock);
    pin <= 1'b0;
    repeat (lo) @(posedge clock);
  endtask

  // move the pin to a level and hold it for some cycles
  task automatic level(input logic v, input int n);
    pin <= v;
    repeat (n) @(posedge clock);
  endtask
endmodule

`default_nettype wire
